// [rtl/keep_alive_pkg.sv]
// constants, status codes and carrier types of the keep-alive watchdog
// Summary of operation
// - the controller declares a keep-alive timeout when neither a keep-alive nor a valid set-timeout command arrives within the configured interval.
// - on expiry the controller emits an error log entry with the expired status code and sets its fatal flag to one.
// - only a keep-alive command or a valid set-timeout command restarts the timeout period; every other command leaves the count alone.
// - a timeout value of zero or above the transport maximum completes with the keep-alive-invalid status.
// - a timeout value below the transport or implementation minimum is rounded up to that minimum.
// - the granularity of the timer is reported as an identification field.
// - a keep-alive command is acted on in the very cycle it is accepted, with no queueing.
// - on a transport that cannot detect connection loss the watchdog is always enabled.
// - on a PCIe-attached controller keep-alive is optional and the transport imposes no bounds.
package keep_alive_pkg;

    // clock and timer granularity
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned GRAN_MS        = 100;
    localparam int unsigned GRAN_CYCLES    = GRAN_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [31:0] GRAN_MS_W      = 32'(GRAN_MS);

    // timeout bounds in milliseconds
    localparam logic [31:0] IMPL_MIN_MS    = 32'(GRAN_MS);
    localparam logic [31:0] FAB_MIN_MS     = 32'h0000_03e8;
    localparam logic [31:0] FAB_MAX_MS     = 32'h0001_d4c0;
    localparam logic [31:0] FAB_DEFAULT_MS = 32'h0000_2710;
    localparam logic [31:0] PCIE_MAX_MS    = 32'hffff_ffff;
    localparam logic [31:0] ZERO_MS        = 32'h0000_0000;

    // completion and log status codes, values arbitrary
    localparam logic [7:0]  ST_SUCCESS     = 8'h00;
    localparam logic [7:0]  ST_KA_INVALID  = 8'h01;
    localparam logic [7:0]  ST_KA_EXPIRED  = 8'h02;

    // watchdog states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_RUN     = 3'b010,
        ST_EXPIRED = 3'b100
    } wd_state_e;

    // command observed on the admin queue
    typedef struct packed {
        logic        keep_alive;
        logic        set_timeout;
        logic [31:0] timeout_ms;
    } cmd_s;

    // completion of a keep-alive or set-timeout command
    typedef struct packed {
        logic [7:0]  status;
        logic [31:0] timeout_ms;
    } rsp_s;

    // error log entry
    typedef struct packed {
        logic [7:0]  status;
    } log_s;

endpackage : keep_alive_pkg

// [rtl/ka_tick_divider.sv]
// granularity tick divider for the keep-alive timer
`timescale 1ns/1ns
module ka_tick_divider #(
    parameter int unsigned CYCLES = 5000000
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic clear,
    output logic      tick
);
    localparam logic [31:0] LAST = 32'(CYCLES - 1);

    logic [31:0] count_q;
    logic [31:0] count_d;

    // one-cycle enable each granularity period; clear restarts the phase
    always_comb begin
        tick    = (count_q == LAST);
        count_d = count_q + 32'h0000_0001;
        if (clear || tick) begin
            count_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            count_q <= 32'h0000_0000;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : ka_tick_divider

// [rtl/keep_alive_watchdog.sv]
// keep-alive watchdog: timeout check, validation of timeout values, fatal flag
`timescale 1ns/1ns
module keep_alive_watchdog #(
    parameter bit          TRANSPORT_PCIE = 1'b0,
    parameter int unsigned TICK_CYCLES    = keep_alive_pkg::GRAN_CYCLES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 cmd_valid,
    input  wire keep_alive_pkg::cmd_s cmd,
    output logic                      cmd_ready,
    output logic                      rsp_valid,
    output keep_alive_pkg::rsp_s      rsp,
    input  wire logic                 rsp_ready,
    output logic                      log_valid,
    output keep_alive_pkg::log_s      log_entry,
    output logic                      controller_fatal_flag,
    output logic                      watchdog_enabled,
    output logic [31:0]               timeout_ms,
    output logic [31:0]               timer_granularity_ms
);
    import keep_alive_pkg::*;

    // transport bounds; the implementation minimum always applies
    localparam logic [31:0] MAX_MS   = TRANSPORT_PCIE ? PCIE_MAX_MS : FAB_MAX_MS;
    localparam logic [31:0] MIN_MS   = (TRANSPORT_PCIE || (FAB_MIN_MS < IMPL_MIN_MS)) ? IMPL_MIN_MS : FAB_MIN_MS;
    localparam logic [31:0] RST_MS   = TRANSPORT_PCIE ? ZERO_MS : FAB_DEFAULT_MS;
    localparam wd_state_e   RST_ST   = TRANSPORT_PCIE ? ST_IDLE : ST_RUN;

    wd_state_e   state_q,   state_d;
    logic [31:0] kato_q,    kato_d;
    logic [31:0] elapsed_q, elapsed_d;
    logic        fatal_q,   fatal_d;
    logic        log_q,     log_d;
    logic        rsp_v_q,   rsp_v_d;
    rsp_s        rsp_q,     rsp_d;
    logic [31:0] gran_q;

    logic        accept;
    logic        ka_req;
    logic        set_req;
    logic        set_bad;
    logic        set_ok;
    logic [31:0] set_val;
    logic        expire;
    logic        restart;
    logic        tick;
    logic [32:0] elapsed_sum;

    // a new command waits only while an unread completion is pending
    assign cmd_ready = !rsp_v_q || rsp_ready;

    // command decode and timeout validation
    always_comb begin
        accept  = cmd_valid && cmd_ready;
        ka_req  = accept && cmd.keep_alive;
        set_req = accept && cmd.set_timeout;
        set_bad = (cmd.timeout_ms == ZERO_MS) || (cmd.timeout_ms > MAX_MS);
        set_ok  = set_req && !set_bad;
        set_val = (cmd.timeout_ms < MIN_MS) ? MIN_MS : cmd.timeout_ms;
    end

    // expiry check and elapsed time in granularity steps
    always_comb begin
        expire      = (state_q == ST_RUN) && (elapsed_q >= kato_q);
        elapsed_sum = {1'b0, elapsed_q} + {1'b0, GRAN_MS_W};
        restart     = ((state_q != ST_EXPIRED) && set_ok) || ((state_q == ST_RUN) && ka_req);
    end

    // granularity ticks; phase restarts with the timer so no partial step is counted
    ka_tick_divider #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clear   (restart),
        .tick    (tick)
    );

    // watchdog state, timeout value and fatal flag
    always_comb begin
        state_d   = state_q;
        kato_d    = kato_q;
        elapsed_d = elapsed_q;
        fatal_d   = fatal_q;
        log_d     = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (set_ok) begin
                    state_d   = ST_RUN;
                    kato_d    = set_val;
                    elapsed_d = ZERO_MS;
                end
            end
            ST_RUN: begin
                if (expire) begin
                    // expiry wins over a keep-alive in the same cycle: the deadline already passed
                    state_d = ST_EXPIRED;
                    fatal_d = 1'b1;
                    log_d   = 1'b1;
                end else if (set_ok) begin
                    kato_d    = set_val;
                    elapsed_d = ZERO_MS;
                end else if (ka_req) begin
                    elapsed_d = ZERO_MS;
                end else if (tick) begin
                    elapsed_d = elapsed_sum[32] ? 32'hffff_ffff : elapsed_sum[31:0];
                end
            end
            ST_EXPIRED: begin
                // fatal until reset; a new value is kept but does not rearm
                if (set_ok) begin
                    kato_d = set_val;
                end
            end
            default: begin
                state_d = ST_EXPIRED;
                fatal_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_q   <= RST_ST;
            kato_q    <= RST_MS;
            elapsed_q <= 32'h0000_0000;
            fatal_q   <= 1'b0;
            log_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            kato_q    <= kato_d;
            elapsed_q <= elapsed_d;
            fatal_q   <= fatal_d;
            log_q     <= log_d;
        end
    end

    // completion for keep-alive and set-timeout; held until taken
    always_comb begin
        rsp_v_d = rsp_v_q;
        rsp_d   = rsp_q;
        if (ka_req || set_req) begin
            rsp_v_d          = 1'b1;
            rsp_d.status     = (set_req && set_bad) ? ST_KA_INVALID : ST_SUCCESS;
            rsp_d.timeout_ms = set_ok ? set_val : kato_q;
        end else if (rsp_ready) begin
            rsp_v_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rsp_v_q <= 1'b0;
            rsp_q   <= '0;
            gran_q  <= 32'h0000_0000;
        end else begin
            rsp_v_q <= rsp_v_d;
            rsp_q   <= rsp_d;
            gran_q  <= GRAN_MS_W;
        end
    end

    assign rsp_valid             = rsp_v_q;
    assign rsp                   = rsp_q;
    assign log_valid             = log_q;
    assign log_entry.status      = log_q ? ST_KA_EXPIRED : ST_SUCCESS;
    assign controller_fatal_flag = fatal_q;
    assign watchdog_enabled      = (state_q != ST_IDLE);
    assign timeout_ms            = kato_q;
    assign timer_granularity_ms  = gran_q;

    // checks on the watchdog behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_deadline;
        (state_q == ST_RUN) && (elapsed_q >= kato_q);
    endsequence

    sequence s_logged;
        log_valid && (log_entry.status == ST_KA_EXPIRED) && controller_fatal_flag;
    endsequence

    property p_expire_on_deadline;
        s_deadline |=> (state_q == ST_EXPIRED);
    endproperty
    a_expire_on_deadline: assert property (p_expire_on_deadline)
        else $error("deadline passed without expiry");

    property p_expire_logs;
        s_deadline |=> s_logged ##1 (!log_valid && controller_fatal_flag);
    endproperty
    a_expire_logs: assert property (p_expire_logs)
        else $error("expiry did not log once and set fatal flag");

    property p_fatal_only_from_expiry;
        $rose(controller_fatal_flag) |-> $past(state_q == ST_RUN) && log_valid;
    endproperty
    a_fatal_only_from_expiry: assert property (p_fatal_only_from_expiry)
        else $error("fatal flag rose without a timer expiry");

    property p_keep_alive_restarts;
        (ka_req && !set_req && (state_q == ST_RUN) && !expire) |=> (elapsed_q == 32'h0000_0000);
    endproperty
    a_keep_alive_restarts: assert property (p_keep_alive_restarts)
        else $error("keep-alive did not restart the timer");

    property p_other_no_restart;
        (state_q == ST_RUN) && !expire && !ka_req && !set_ok && (elapsed_q != 32'h0000_0000)
            |=> (elapsed_q != 32'h0000_0000) && (elapsed_q >= $past(elapsed_q));
    endproperty
    a_other_no_restart: assert property (p_other_no_restart)
        else $error("timer restarted without a keep-alive");

    property p_invalid_rejected;
        (set_req && set_bad && !ka_req) |=> rsp_valid && (rsp.status == ST_KA_INVALID)
            && (timeout_ms == $past(timeout_ms));
    endproperty
    a_invalid_rejected: assert property (p_invalid_rejected)
        else $error("invalid timeout not rejected");

    property p_round_up;
        (set_ok && (state_q != ST_EXPIRED) && !expire && (cmd.timeout_ms < MIN_MS))
            |=> (timeout_ms == MIN_MS) && (rsp.status == ST_SUCCESS) && (elapsed_q == 32'h0000_0000);
    endproperty
    a_round_up: assert property (p_round_up)
        else $error("short timeout not rounded up to minimum");

    // field still reads zero on the first edge after release, so look one cycle on
    property p_granularity;
        reset_n |=> (timer_granularity_ms == GRAN_MS_W);
    endproperty
    a_granularity: assert property (p_granularity)
        else $error("granularity field wrong");

    property p_required_enabled;
        !TRANSPORT_PCIE |-> watchdog_enabled;
    endproperty
    a_required_enabled: assert property (p_required_enabled)
        else $error("mandatory watchdog found disabled");

    property p_tick_step;
        (state_q == ST_RUN) && !expire && !ka_req && !set_ok && tick && (elapsed_q < 32'h0fff_ffff)
            |=> (elapsed_q == $past(elapsed_q) + GRAN_MS_W);
    endproperty
    a_tick_step: assert property (p_tick_step)
        else $error("timer did not advance by one granularity step");

endmodule : keep_alive_watchdog

// [verif/host_model.sv]
// host-side driver model that issues admin commands and takes completions
`timescale 1ns/1ns
module host_model (
    input  wire logic            ref_clk,
    input  wire logic            cmd_ready,
    input  wire logic            slow,
    output logic                 cmd_valid,
    output keep_alive_pkg::cmd_s cmd,
    output logic                 rsp_ready
);
    import keep_alive_pkg::*;

    // quiet bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
        rsp_ready = 1'b1;
    end

    // completion consumer; slow mode stalls completions to exercise back-pressure
    always @(posedge ref_clk) begin
        rsp_ready <= !slow;
    end

    // present a command without waiting; only safe while cmd_ready is known high
    task automatic put(input cmd_s c);
        cmd_valid <= 1'b1;
        cmd       <= c;
    endtask : put

    // present and hold until taken; caller paces keep-alives below the timeout
    task automatic send(input logic ka, input logic st, input logic [31:0] v);
        put('{keep_alive: ka, set_timeout: st, timeout_ms: v});
        @(posedge ref_clk);
        while (cmd_ready !== 1'b1) @(posedge ref_clk);
    endtask : send

    // release: lines show the inverse so a stale value never looks valid
    task automatic idle();
        cmd_valid <= 1'b0;
        cmd       <= ~cmd;
    endtask : idle
endmodule : host_model

// [verif/test_keep_alive_watchdog.sv]
// self-checking bench for the keep-alive watchdog, fabric transport
`timescale 1ns/1ns
module test_keep_alive_watchdog;
    import keep_alive_pkg::*;
    localparam int unsigned TK = 4;
    typedef struct {logic ka; logic st; logic [31:0] v; logic [7:0] s; logic [31:0] t;} row_s;
    logic        ref_clk, reset_n, slow, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
    logic        log_valid, fatal, enabled, p_fatal, p_en;
    logic [31:0] p_tmo;
    cmd_s        cmd;
    rsp_s        rsp;
    log_s        log_entry;
    logic [31:0] tmo, gran;
    int          fail_count, compares, cycles, n, logs, base;
    // set values: zero, below minimum, the maximum, above maximum, in range, below minimum, all ones, then a keep-alive
    row_s rows [8] = '{'{0, 1, 32'h0, ST_KA_INVALID, 32'h2710}, '{0, 1, 32'h1f4, ST_SUCCESS, 32'h3e8},
                       '{0, 1, 32'h1d4c0, ST_SUCCESS, 32'h1d4c0}, '{0, 1, 32'h1d4c1, ST_KA_INVALID, 32'h1d4c0},
                       '{0, 1, 32'h7d0, ST_SUCCESS, 32'h7d0}, '{0, 1, 32'h32, ST_SUCCESS, 32'h3e8},
                       '{0, 1, 32'hffff_ffff, ST_KA_INVALID, 32'h3e8}, '{1, 0, 32'h0, ST_SUCCESS, 32'h3e8}};

    keep_alive_watchdog #(.TRANSPORT_PCIE(1'b0), .TICK_CYCLES(TK)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready), .log_valid(log_valid), .log_entry(log_entry),
        .controller_fatal_flag(fatal), .watchdog_enabled(enabled), .timeout_ms(tmo), .timer_granularity_ms(gran));
    // optional-watchdog copy sees the same commands; its completions pair alike, so its ready matches
    keep_alive_watchdog #(.TRANSPORT_PCIE(1'b1), .TICK_CYCLES(TK)) dut_pcie (
        .ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(),
        .rsp_valid(), .rsp(), .rsp_ready(rsp_ready), .log_valid(), .log_entry(),
        .controller_fatal_flag(p_fatal), .watchdog_enabled(p_en), .timeout_ms(p_tmo), .timer_granularity_ms());
    host_model host (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .slow(slow), .cmd_valid(cmd_valid), .cmd(cmd),
        .rsp_ready(rsp_ready));

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    // error-log pulse count and hang guard
    always @(posedge ref_clk) begin
        if (log_valid === 1'b1) logs++;
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    // one command with its single completion one cycle later
    task automatic txn(input logic ka, input logic st, input logic [31:0] v, input logic [7:0] s,
                       input logic [31:0] t);
        host.send(ka, st, v);
        host.idle();
        @(posedge ref_clk);
        check(rsp_valid, 1, "completion");
        check(rsp.status, s, "status");
        check(rsp.timeout_ms, t, "rsp timeout");
        check(tmo, t, "timeout");
    endtask : txn

    task automatic reset_checks();
        check(fatal, 0, "fatal after reset");
        check(tmo, 32'h2710, "default timeout");
        check(enabled, 1, "enabled");
        check(gran, 32'h64, "granularity");
        check(rsp_valid, 0, "no completion");
        check(p_en, 0, "optional watchdog idle");
        check(p_tmo, 0, "optional watchdog timeout");
    endtask : reset_checks

    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        slow    = 1'b0;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset_checks();
        foreach (rows[i]) txn(rows[i].ka, rows[i].st, rows[i].v, rows[i].s, rows[i].t);
        // no upper bound on the optional transport: the all-ones value was taken
        check(p_tmo, 32'hffff_ffff, "optional no maximum");
        check(p_en, 1, "optional armed by set");
        // keep-alives spaced under the interval keep the watchdog quiet
        for (int k = 0; k < 6; k++) begin
            repeat (TK * 10 - 8) @(posedge ref_clk);
            txn(1, 0, 0, ST_SUCCESS, 32'h3e8);
        end
        check(fatal, 0, "refreshed");
        check(logs, 0, "no log");
        // restart by a new timeout, then other commands only: must still expire
        host.send(0, 1, 32'h3e8);
        for (n = 0; n < 200 && log_valid !== 1'b1; n++) begin
            if (n % 8 == 4) host.put('{keep_alive: 1'b0, set_timeout: 1'b0, timeout_ms: 32'(n)});
            else host.idle();
            @(posedge ref_clk);
        end
        host.idle();
        check(n >= TK * 10 && n <= TK * 10 + 3, 1, "expiry time");
        check(log_entry.status, ST_KA_EXPIRED, "log status");
        check(fatal, 1, "fatal set");
        check(p_fatal, 1, "optional fatal set");
        @(posedge ref_clk);
        check(log_valid, 0, "log pulse");
        // keep-alive after expiry completes but does not rearm
        base = logs;
        txn(1, 0, 0, ST_SUCCESS, 32'h3e8);
        repeat (60) @(posedge ref_clk);
        check(logs - base, 0, "single log");
        check(fatal, 1, "fatal sticky");
        // stalled completion holds and blocks new commands
        slow <= 1'b1;
        @(posedge ref_clk);
        host.send(1, 0, 0);
        host.idle();
        repeat (3) begin
            @(posedge ref_clk);
            check(rsp_valid, 1, "held completion");
            check(cmd_ready, 0, "refused");
        end
        slow <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(rsp_valid, 0, "completion taken");
        // second reset in mid-run clears the fatal flag
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset_checks();
        close_out();
    end
endmodule : test_keep_alive_watchdog
